// ==== verilog/dsr_pkg.sv ====
// Package: constants and types for the DAC two-wire register bank
package dsr_pkg;

  // ==========================================================
  // Command codes and slave address
  localparam logic [7:0] DSR_CMD_CODE   = 8'h00;
  localparam logic [7:0] DSR_CMD_CONFIG = 8'h01;
  localparam logic [6:0] DSR_SLAVE_ADDR = 7'h48;

  // ==========================================================
  // Register widths, fields and reset values
  localparam int          DSR_CODE_W       = 12;
  localparam int          DSR_STANDBY_BIT  = 0;
  localparam logic [11:0] DSR_CODE_RESET   = 12'h000;
  localparam logic [7:0]  DSR_CONFIG_RESET = 8'h00;
  localparam logic [7:0]  DSR_CMD_RESET    = 8'h00;
  localparam int          DSR_FULL_SCALE   = 4096;
  localparam logic [3:0]  DSR_BYTE_LAST    = 4'h7;
  localparam logic [3:0]  DSR_ACK_SLOT     = 4'h8;
  // Start value of the bit count; the clock fall that closes a start
  // wraps it to zero, so that fall is not taken for a data bit
  localparam logic [3:0]  DSR_CNT_START    = 4'hF;

  // ==========================================================
  // Converter-facing bundle
  typedef struct packed {
    logic [11:0] code;
    logic        standby;
  } dsr_dac_t;

  // Bit-level bus events from the link receiver
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } dsr_link_t;

endpackage

// ==== verilog/dsr_link_sync.sv ====
// Two-wire pin synchroniser and bus event detector
`timescale 1ns/1ps
module dsr_link_sync (
  // Clock and reset
  input  wire logic            clk_sys_i,
  input  wire logic            reset_i,
  // Raw pins
  input  wire logic            scl_i,
  input  wire logic            sda_i,
  // Events
  output dsr_pkg::dsr_link_t   link_o
);
  import dsr_pkg::*;

  logic [1:0] scl_meta;
  logic [1:0] sda_meta;
  logic       scl_d;
  logic       sda_d;
  logic [1:0] next_scl_meta;
  logic [1:0] next_sda_meta;

  // ==========================================================
  // Two-stage sync; only stage 2 is read by edge logic
  always_comb begin
    next_scl_meta = {scl_meta[0], scl_i};
    next_sda_meta = {sda_meta[0], sda_i};
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_meta <= next_scl_meta;
      sda_meta <= next_sda_meta;
      scl_d    <= scl_meta[1];
      sda_d    <= sda_meta[1];
    end
  end

  // Start and stop are data edges while the clock line is high
  always_comb begin
    link_o.start    = scl_meta[1] & scl_d & sda_d & ~sda_meta[1];
    link_o.stop     = scl_meta[1] & scl_d & ~sda_d & sda_meta[1];
    link_o.scl_rise = scl_meta[1] & ~scl_d;
    link_o.scl_fall = ~scl_meta[1] & scl_d;
    link_o.sda      = sda_meta[1];
  end

endmodule

// ==== verilog/dsr_bank.sv ====
// DAC register bank behind a two-wire slave port
`timescale 1ns/1ps
// Contract
// RL1 - Command 00h selects the code register, 01h the configuration register
// RL2 - Config bit 0 is standby; bits 7..1 ignore writes and read zero
// RL3 - Code is 12 bits in two bytes; first byte holds bits 11..4 MSB first
// RL4 - Second byte upper nibble holds bits 3..0; low nibble ignored on write
// RL5 - Stored code goes to the converter; output is reference times code/4096
// RL6 - Reset clears code and configuration: normal mode, zero code
// RL7 - Acknowledge only address 1001000; eighth bit one means read
// RL8 - Write: address, command, then one or two data bytes to that register
// RL9 - Read with no command returns the register last selected
// RL10 - Bytes go MSB first; receiver acknowledges; master ends read with NACK
module dsr_bank (
  // Clock and reset
  input  wire logic            clk_sys_i,
  input  wire logic            reset_i,
  // Two-wire link, data line split into in/out/enable
  input  wire logic            scl_i,
  input  wire logic            sda_i,
  output logic                 sda_o,
  output logic                 sda_oe_o,
  // Converter side
  output dsr_pkg::dsr_dac_t    dac_o
);
  import dsr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA, ST_RACK
  } dsr_state_t;

  dsr_link_t   link;
  dsr_state_t  state, next_state;
  logic [3:0]  bit_cnt, next_bit_cnt;
  logic [7:0]  shift, next_shift;
  logic [7:0]  cmd, next_cmd;
  logic [11:0] code, next_code;
  logic [7:0]  config_reg, next_config_reg;
  logic        byte_idx, next_byte_idx;
  logic        drive, next_drive;
  logic        rd_mode, next_rd_mode;
  logic [7:0]  rd_byte;

  // ==========================================================
  // Pin synchroniser and event detector
  dsr_link_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .link_o    (link)
  );

  // Read byte: first byte code high, second code low nibble, config padded
  always_comb begin
    if (cmd == DSR_CMD_CONFIG) begin
      rd_byte = {7'h00, config_reg[DSR_STANDBY_BIT]}; // RL2
    end else if (!byte_idx) begin
      rd_byte = code[11:4]; // RL3
    end else begin
      rd_byte = {code[3:0], 4'h0}; // RL4
    end
  end

  // ==========================================================
  // Protocol engine next-state
  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shift      = shift;
    next_cmd        = cmd;
    next_code       = code;
    next_config_reg = config_reg;
    next_byte_idx   = byte_idx;
    next_drive      = drive;
    next_rd_mode    = rd_mode;
    if (link.stop) begin
      next_state = ST_IDLE;
      next_drive = 1'b0;
    end else if (link.start) begin
      // Repeated start also lands here
      next_state    = ST_ADDR;
      next_bit_cnt  = DSR_CNT_START; // RL7
      next_byte_idx = 1'b0;
      next_drive    = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_drive = 1'b0;
        end
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (link.scl_rise && bit_cnt <= DSR_BYTE_LAST) begin
            next_shift = {shift[6:0], link.sda}; // RL10
          end
          if (link.scl_fall) begin
            if (bit_cnt == DSR_BYTE_LAST) begin
              next_bit_cnt = DSR_ACK_SLOT;
              next_drive   = 1'b1; // RL10
              next_shift   = shift;
              if (state == ST_ADDR) begin
                if (shift[7:1] != DSR_SLAVE_ADDR) begin
                  next_state = ST_IDLE; // RL7
                  next_drive = 1'b0;
                end
                next_rd_mode = shift[0]; // RL7
              end else if (state == ST_CMD) begin
                next_cmd = shift; // RL1
              end else if (cmd == DSR_CMD_CONFIG) begin
                next_config_reg = {7'h00, shift[DSR_STANDBY_BIT]}; // RL2
              end else if (!byte_idx) begin
                next_code[11:4] = shift; // RL3 RL8
              end else begin
                next_code[3:0] = shift[7:4]; // RL4 RL8
              end
            end else if (bit_cnt == DSR_ACK_SLOT) begin
              next_drive   = 1'b0;
              next_bit_cnt = 4'h0;
              if (state == ST_ADDR) begin
                if (rd_mode) begin
                  // Receive: last command decides source
                  next_state = ST_RDATA; // RL9
                  next_drive = 1'b1;
                end else begin
                  next_state = ST_CMD;
                end
              end else if (state == ST_CMD) begin
                next_state = ST_WDATA; // RL8
              end else begin
                next_byte_idx = 1'b1;
              end
            end else begin
              next_bit_cnt = bit_cnt + 4'h1;
            end
          end
        end
        ST_RDATA: begin
          if (link.scl_fall) begin
            if (bit_cnt == DSR_BYTE_LAST) begin
              next_drive   = 1'b0;
              next_bit_cnt = 4'h0;
              next_state   = ST_RACK;
            end else begin
              next_bit_cnt = bit_cnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (link.scl_rise) begin
            // Master NACK ends the read
            if (link.sda) begin
              next_state = ST_IDLE; // RL10
            end else begin
              next_byte_idx = 1'b1;
            end
          end
          if (link.scl_fall && state == ST_RACK) begin
            next_state = ST_RDATA;
            next_drive = 1'b1;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // Registers clear to normal mode and zero code
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      cmd        <= DSR_CMD_RESET;
      code       <= DSR_CODE_RESET; // RL6
      config_reg <= DSR_CONFIG_RESET; // RL6
      byte_idx   <= 1'b0;
      drive      <= 1'b0;
      rd_mode    <= 1'b0;
    end else begin
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      shift      <= next_shift;
      cmd        <= next_cmd;
      code       <= next_code;
      config_reg <= next_config_reg;
      byte_idx   <= next_byte_idx;
      drive      <= next_drive;
      rd_mode    <= next_rd_mode;
    end
  end

  // ==========================================================
  // Data line: ack pulls low, read shifts MSB first (open drain)
  always_comb begin
    sda_o    = 1'b0;
    sda_oe_o = 1'b0;
    if (drive && state == ST_RDATA) begin
      sda_oe_o = ~rd_byte[3'(DSR_BYTE_LAST - bit_cnt)]; // RL10
    end else if (drive) begin
      sda_oe_o = 1'b1;
    end
  end

  // Converter gets the stored code; full scale is 4096 steps
  always_comb begin
    dac_o.code    = code; // RL5
    dac_o.standby = config_reg[DSR_STANDBY_BIT]; // RL2
  end

  // ==========================================================
  // Checks
  a_cfg_reserved_zero: assert property ( // RL2
    @(posedge clk_sys_i) disable iff (reset_i) config_reg[7:1] == 7'h00)
    else $error("reserved config bits set");

  a_dac_tracks_code: assert property ( // RL5
    @(posedge clk_sys_i) disable iff (reset_i)
    $changed(dac_o.code) |->
      $past(cmd) != DSR_CMD_CONFIG && dac_o.code < DSR_FULL_SCALE)
    else $error("converter code mismatch");

  a_ack_only_addr: assert property ( // RL7
    @(posedge clk_sys_i) disable iff (reset_i)
    (state == ST_ADDR && drive) |-> shift[7:1] == DSR_SLAVE_ADDR)
    else $error("ack for foreign address");

  a_cmd_only_in_cmd: assert property ( // RL1
    @(posedge clk_sys_i) disable iff (reset_i)
    $changed(cmd) |-> $past(state) == ST_CMD)
    else $error("command changed outside command phase");

  a_code_write_phase: assert property ( // RL8
    @(posedge clk_sys_i) disable iff (reset_i)
    $changed(code) |-> $past(state) == ST_WDATA)
    else $error("code changed outside write");

  a_read_no_cmd: assert property ( // RL9
    @(posedge clk_sys_i) disable iff (reset_i)
    state == ST_RDATA |-> $stable(cmd))
    else $error("command moved during read");

  a_line_low_only: assert property ( // RL10
    @(posedge clk_sys_i) disable iff (reset_i) sda_o == 1'b0)
    else $error("data line driven high");

  a_stop_releases: assert property ( // RL10
    @(posedge clk_sys_i) disable iff (reset_i)
    link.stop |=> !sda_oe_o && state == ST_IDLE)
    else $error("line held after stop");

endmodule

// ==== testbench/dsr_host_model.sv ====
// Host master model that drives the two-wire bus from the far side
`timescale 1ns/1ps
module dsr_host_model (
  // Clock
  input  wire logic clk_i,
  // Bus lines
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // ==========================================================
  // Idle bus stands high on both lines
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // A quarter bit is two system clocks, so one bit lasts 320 ns
  task q;
    repeat (2) @(posedge clk_i);
  endtask

  // Data changes only while the clock is low
  task send_bit(input logic b);
    sda_low_o <= ~b;
    q;
    scl_o <= 1'b1;
    q;
    q;
    scl_o <= 1'b0;
    q;
  endtask

  // Start or repeated start: data falls while the clock is high
  task go_start;
    sda_low_o <= 1'b0;
    q;
    scl_o <= 1'b1;
    q;
    sda_low_o <= 1'b1;
    q;
    scl_o <= 1'b0;
    q;
  endtask

  // Stop: data rises while the clock is high
  task go_stop;
    sda_low_o <= 1'b1;
    q;
    scl_o <= 1'b1;
    q;
    sda_low_o <= 1'b0;
    q;
  endtask

  // Byte out MSB first, then release the line for the ninth clock
  task send_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i]);
    end
    sda_low_o <= 1'b0;
    q;
    scl_o <= 1'b1;
    q;
    ack = ~sda_i;
    q;
    scl_o <= 1'b0;
    q;
  endtask

  // Byte in MSB first; the last byte of a read ends with a NACK
  task recv_byte(input logic nack, output logic [7:0] d);
    sda_low_o <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      q;
      scl_o <= 1'b1;
      q;
      d[i] = sda_i;
      q;
      scl_o <= 1'b0;
      q;
    end
    send_bit(nack);
  endtask
endmodule

// ==== testbench/dsr_bank_tb_top.sv ====
// Self-checking bench for the DAC two-wire register bank
`timescale 1ns/1ps
module dsr_bank_tb_top;
  import dsr_pkg::*;
  logic       clk_sys_i = 1'b0;
  logic       reset_i = 1'b1;
  logic       scl;
  logic       host_low;
  logic       sda_o;
  logic       sda_oe_o;
  logic       ack;
  logic [7:0] b0;
  logic [7:0] b1;
  dsr_dac_t   dac;
  int         fails = 0;
  int         checks_done = 0;
  // Pulled-up data line: low while either party pulls it
  wire        sda_line = ~host_low & ~(sda_oe_o & ~sda_o);

  always #20 clk_sys_i = ~clk_sys_i;

  dsr_host_model u_host (.clk_i(clk_sys_i), .sda_i(sda_line),
    .scl_o(scl), .sda_low_o(host_low));
  dsr_bank u_dsr_bank (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .dac_o(dac));

  // ==========================================================
  // Compare and report
  task chk_val(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // Bus transfers
  task addr(input logic rd);
    u_host.send_byte({DSR_SLAVE_ADDR, rd}, ack);
    chk_val({11'h0, ack}, 12'h001);
  endtask

  task wr_reg(input logic [7:0] cmd, d0, d1, input int n);
    u_host.go_start();
    addr(1'b0);
    u_host.send_byte(cmd, ack);
    chk_val({11'h0, ack}, 12'h001);
    u_host.send_byte(d0, ack);
    chk_val({11'h0, ack}, 12'h001);
    if (n > 1) begin
      u_host.send_byte(d1, ack);
      chk_val({11'h0, ack}, 12'h001);
    end
    u_host.go_stop();
  endtask

  // Without a command byte the read uses the last register selected
  task rd_reg(input logic [7:0] cmd, input logic sel, input int n);
    u_host.go_start();
    if (sel) begin
      addr(1'b0);
      u_host.send_byte(cmd, ack);
      chk_val({11'h0, ack}, 12'h001);
      u_host.go_start();
    end
    addr(1'b1);
    u_host.recv_byte(n == 1, b0);
    if (n > 1)
      u_host.recv_byte(1'b1, b1);
    u_host.go_stop();
  endtask

  // ==========================================================
  // Scenarios
  task t_code;
    wr_reg(DSR_CMD_CODE, 8'hA5, 8'hC7, 2);
    chk_val(dac.code, 12'hA5C);
    rd_reg(DSR_CMD_CODE, 1'b1, 2);
    chk_val({b0, b1[7:4]}, 12'hA5C);
    chk_val({8'h0, b1[3:0]}, 12'h000);
    wr_reg(DSR_CMD_CODE, 8'h3C, 8'h00, 1);
    chk_val(dac.code, 12'h3CC);
  endtask

  task t_config;
    wr_reg(DSR_CMD_CONFIG, 8'hFF, 8'h00, 1);
    chk_val({11'h0, dac.standby}, 12'h001);
    chk_val(dac.code, 12'h3CC);
    rd_reg(DSR_CMD_CONFIG, 1'b1, 1);
    chk_val({4'h0, b0}, 12'h001);
    rd_reg(DSR_CMD_CODE, 1'b0, 1);
    chk_val({4'h0, b0}, 12'h001);
    wr_reg(DSR_CMD_CONFIG, 8'hFE, 8'h00, 1);
    chk_val({11'h0, dac.standby}, 12'h000);
  endtask

  // A neighbouring address must be ignored until the next start
  task t_bad_addr;
    u_host.go_start();
    u_host.send_byte({DSR_SLAVE_ADDR ^ 7'h01, 1'b0}, ack);
    chk_val({11'h0, ack}, 12'h000);
    u_host.send_byte(DSR_CMD_CODE, ack);
    u_host.send_byte(8'h77, ack);
    u_host.go_stop();
    chk_val(dac.code, 12'h3CC);
  endtask

  // ==========================================================
  // Main sequence and a watchdog against a hung run
  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk_val(dac.code, DSR_CODE_RESET);
    chk_val({11'h0, dac.standby}, 12'h000);
    t_code();
    t_config();
    t_bad_addr();
    final_report();
  end

  initial begin
    repeat (100000) @(posedge clk_sys_i);
    fails++;
    final_report();
  end
endmodule
